/* File: pkg/pesnl_pkg.sv */
/*
  Shared constants and carriers for the performance event selector of the
  node-controller/home unit and the link-layer units.
  Assumes a single core clock and an APB master with 32-bit data.
*/
//
// Summary of operation
// - ECC selection comes from home select word bits 33 to 30.
// - Each ECC bit enables one single or double error type, any combination.
// - Output-interface selection comes from home select word bits 36 to 34.
// - Interface field picks one direction and one of packet, flit, starved.
// - Traffic-match selection comes from home select word bits 73 to 37.
// - Only one link-layer path selection works; all other path selections never count.
// - Link-layer interface selection comes from link select word bits 32 to 25.
// - Path select chooses exactly one traffic path; output buffer flits 0-1 usable.
// - Path event chooses one of packet, packet idle latency, flit, starved.
package pesnl_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_HOME_LO  = 8'h00;
  localparam logic [7:0] OFS_HOME_MID = 8'h04;
  localparam logic [7:0] OFS_HOME_HI  = 8'h08;
  localparam logic [7:0] OFS_LL_LO    = 8'h0C;
  localparam logic [7:0] OFS_LL_HI    = 8'h10;
  localparam logic [7:0] OFS_SETUP    = 8'h14;
  localparam logic [7:0] OFS_COUNT    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // Select word widths and field positions.
  localparam int HOME_W    = 74;
  localparam int LL_W      = 33;
  localparam int ECC_LSB   = 30;
  localparam int ECC_MSB   = 33;
  localparam int IF_LSB    = 34;
  localparam int IF_MSB    = 36;
  localparam int TM_LSB    = 37;
  localparam int TM_MSB    = 73;
  localparam int LL_EV_LSB = 25;
  localparam int LL_EV_MSB = 27;
  localparam int LL_PS_LSB = 28;
  localparam int LL_PS_MSB = 32;
  localparam int NID_W     = 5;
  localparam int LL_N      = 9;

  // Encodings.
  localparam logic [1:0] IF_PACKET     = 2'h1;
  localparam logic [1:0] IF_FLIT       = 2'h2;
  localparam logic [1:0] IF_STARVE     = 2'h3;
  localparam logic [4:0] LL_PS_GOOD    = 5'h11;
  localparam logic [2:0] LL_PACKET     = 3'h1;
  localparam logic [2:0] LL_IDLE       = 3'h2;
  localparam logic [2:0] LL_FLIT       = 3'h3;
  localparam logic [2:0] LL_STARVE     = 3'h4;
  localparam logic [2:0] EN_LOCAL      = 3'h1;
  localparam logic [2:0] EVSRC_UNIT    = 3'h0;
  localparam logic [2:0] RST_NONE      = 3'h0;
  localparam logic [1:0] CMP_OFF       = 2'h0;
  localparam logic [1:0] MODE_EVENTS   = 2'h0;
  localparam logic [1:0] UTYPE_HOME    = 2'h0;
  localparam logic [1:0] UTYPE_LL      = 2'h1;
  localparam logic [8:0] USRC_HOME     = 9'h001;
  localparam logic [31:0] SETUP_RESET  = 32'h00000000;
  localparam logic [31:0] COUNT_MAX    = 32'hFFFFFFFF;

  // Interrupt status bits.
  localparam int IRQ_W    = 3;
  localparam int IRQ_HOME = 0;
  localparam int IRQ_LL   = 1;
  localparam int IRQ_WRAP = 2;

  typedef struct packed {
    logic             reserved;
    logic [1:0]       unit_type;
    logic [LL_N-1:0]  unit_src;
    logic [1:0]       spare;
    logic [1:0]       compare;
    logic [2:0]       reset_src;
    logic [2:0]       event_src;
    logic [1:0]       mode;
    logic [2:0]       status_out;
    logic [2:0]       enable_src;
    logic [1:0]       low_spare;
  } pesnl_setup_s;

  typedef struct packed {
    logic             rev_dir;
    logic [NID_W-1:0] dest_node_id;
    logic [NID_W-1:0] dest_node_id_mask;
    logic [NID_W-1:0] requester_node_id;
    logic [NID_W-1:0] requester_node_id_mask;
    logic [3:0]       message_class;
    logic [3:0]       message_class_mask;
    logic [3:0]       opcode_value;
    logic [3:0]       opcode_mask;
  } pesnl_match_s;

  typedef struct packed {
    logic             valid;
    logic [NID_W-1:0] dest_node_id;
    logic [NID_W-1:0] requester_node_id;
    logic [3:0]       message_class;
    logic [3:0]       opcode_value;
  } pesnl_pkt_s;

  typedef struct packed {
    logic packet_emitted;
    logic flit_emitted;
    logic credit_starved;
  } pesnl_obuf_s;

  typedef struct packed {
    logic packet_emitted;
    logic packet_idle_latency;
    logic flit_emitted;
    logic credit_starved;
  } pesnl_ll_ev_s;

endpackage

/* File: hw/pesnl_traffic_match.sv */
/*
  Traffic matcher for the home unit: compares one packet header per cycle
  in the selected direction against programmed values under masks.
  Assumes header inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module pesnl_traffic_match
  import pesnl_pkg::*;
(
  input  wire pesnl_pkg::pesnl_match_s i_cfg,
  input  wire pesnl_pkg::pesnl_pkt_s   i_fwd_pkt,
  input  wire pesnl_pkg::pesnl_pkt_s   i_rev_pkt,
  output logic                         o_hit
);
  import pesnl_pkg::*;

  wire pesnl_pkt_s pkt     = i_cfg.rev_dir ? i_rev_pkt : i_fwd_pkt;
  wire             dest_ok = ((pkt.dest_node_id ^ i_cfg.dest_node_id) & i_cfg.dest_node_id_mask) == '0;
  wire             req_ok  = ((pkt.requester_node_id ^ i_cfg.requester_node_id)
                              & i_cfg.requester_node_id_mask) == '0;
  wire             cls_ok  = ((pkt.message_class ^ i_cfg.message_class) & i_cfg.message_class_mask) == '0;
  wire             opc_ok  = ((pkt.opcode_value ^ i_cfg.opcode_value) & i_cfg.opcode_mask) == '0;

  // A mask bit of one enables comparison of that bit position.
  assign o_hit = pkt.valid & dest_ok & req_ok & cls_ok & opc_ok;

endmodule // pesnl_traffic_match

/* File: hw/pesnl_ll_path.sv */
/*
  Link-layer interface event selector: picks one path event from each
  link-layer instance enabled by the source mask and merges them.
  Assumes instance events come from logic on the same clock.
*/
`timescale 1ns/1ps
module pesnl_ll_path
  import pesnl_pkg::*;
#(
  parameter int N = 9
) (
  input  wire logic [4:0]                  i_path_select,
  input  wire logic [2:0]                  i_path_event,
  input  wire logic [N-1:0]                i_src_mask,
  input  wire pesnl_pkg::pesnl_ll_ev_s [N-1:0] i_ev,
  output logic                             o_hit
);
  import pesnl_pkg::*;

  logic [N-1:0] inst_hit;

  // Only the output buffer flit 0 and 1 path is wired correctly.
  wire path_ok = i_path_select == LL_PS_GOOD;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_inst
      wire ev_sel = (i_path_event == LL_PACKET) ? i_ev[g].packet_emitted :
                    (i_path_event == LL_IDLE) ? i_ev[g].packet_idle_latency :
                    (i_path_event == LL_FLIT) ? i_ev[g].flit_emitted :
                    (i_path_event == LL_STARVE) ? i_ev[g].credit_starved : 1'b0;
      assign inst_hit[g] = i_src_mask[g] & ev_sel;
    end
  endgenerate

  assign o_hit = path_ok & (|inst_hit);

endmodule // pesnl_ll_path

/* File: hw/pesnl_top.sv */
/*
  Performance event selector for the home unit and the link-layer units,
  with one event counter, an APB register slave and a level interrupt.
  Assumes the APB master and all event sources run on i_sys_clk.
*/
`timescale 1ns/1ps
module pesnl_top
  import pesnl_pkg::*;
(
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst,
  input  wire logic [7:0]                      i_paddr,
  input  wire logic                            i_psel,
  input  wire logic                            i_penable,
  input  wire logic                            i_pwrite,
  input  wire logic [31:0]                     i_pwdata,
  output logic [31:0]                          o_prdata,
  output logic                                 o_pready,
  output logic                                 o_pslverr,
  input  wire logic [3:0]                      i_ecc_err,
  input  wire pesnl_pkg::pesnl_obuf_s          i_fwd_obuf,
  input  wire pesnl_pkg::pesnl_obuf_s          i_rev_obuf,
  input  wire pesnl_pkg::pesnl_pkt_s           i_fwd_pkt,
  input  wire pesnl_pkg::pesnl_pkt_s           i_rev_pkt,
  input  wire pesnl_pkg::pesnl_ll_ev_s [8:0]   i_ll_ev,
  output logic                                 o_home_event,
  output logic                                 o_ll_event,
  output logic                                 o_irq
);
  import pesnl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [HOME_W-1:0] home_unit_event_select;
  logic [LL_W-1:0]   link_layer_event_select;
  pesnl_setup_s      counter_setup_word;
  logic [31:0]       count;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [31:0]       prdata;
  logic              pslverr;
  logic              home_event;
  logic              ll_event;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  wire setup_phase  = i_psel & ~i_penable;
  wire access_phase = i_psel & i_penable;
  wire wr_en        = access_phase & i_pwrite;

  wire hit_home_lo  = i_paddr == OFS_HOME_LO;
  wire hit_home_mid = i_paddr == OFS_HOME_MID;
  wire hit_home_hi  = i_paddr == OFS_HOME_HI;
  wire hit_ll_lo    = i_paddr == OFS_LL_LO;
  wire hit_ll_hi    = i_paddr == OFS_LL_HI;
  wire hit_setup    = i_paddr == OFS_SETUP;
  wire hit_count    = i_paddr == OFS_COUNT;
  wire hit_stat     = i_paddr == OFS_IRQ_STAT;
  wire hit_mask     = i_paddr == OFS_IRQ_MASK;
  wire hit_any      = hit_home_lo | hit_home_mid | hit_home_hi | hit_ll_lo | hit_ll_hi |
                      hit_setup | hit_count | hit_stat | hit_mask;

  wire [31:0] rd_mux =
    hit_home_lo  ? home_unit_event_select[31:0] :
    hit_home_mid ? home_unit_event_select[63:32] :
    hit_home_hi  ? {22'h000000, home_unit_event_select[HOME_W-1:64]} :
    hit_ll_lo    ? link_layer_event_select[31:0] :
    hit_ll_hi    ? {31'h00000000, link_layer_event_select[LL_W-1]} :
    hit_setup    ? counter_setup_word :
    hit_count    ? count :
    hit_stat     ? {29'h00000000, irq_stat} :
    hit_mask     ? {29'h00000000, irq_mask} : 32'h00000000;

  // Zero wait states: read data and error are captured in the setup phase.
  assign o_pready  = 1'b1;
  assign o_prdata  = prdata;
  assign o_pslverr = pslverr;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= i_pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select and setup word storage.

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      home_unit_event_select <= '0;
    end else if (wr_en) begin
      if (hit_home_lo) begin
        home_unit_event_select[31:0] <= i_pwdata;
      end
      if (hit_home_mid) begin
        home_unit_event_select[63:32] <= i_pwdata;
      end
      if (hit_home_hi) begin
        home_unit_event_select[HOME_W-1:64] <= i_pwdata[9:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      link_layer_event_select <= '0;
    end else if (wr_en) begin
      if (hit_ll_lo) begin
        link_layer_event_select[31:0] <= i_pwdata;
      end
      if (hit_ll_hi) begin
        link_layer_event_select[LL_W-1] <= i_pwdata[0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      counter_setup_word <= SETUP_RESET;
    end else if (wr_en & hit_setup) begin
      counter_setup_word <= i_pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Home unit field extraction.

  wire [3:0]   ecc_sel  = home_unit_event_select[ECC_MSB:ECC_LSB];
  wire [2:0]   if_sel   = home_unit_event_select[IF_MSB:IF_LSB];
  wire pesnl_match_s tm_cfg = home_unit_event_select[TM_MSB:TM_LSB];
  wire         tm_on    = |home_unit_event_select[TM_MSB:TM_LSB];

  // Bits 0 and 2 are forward single and double, bits 1 and 3 the reverse ones.
  wire         ecc_hit  = |(ecc_sel & i_ecc_err);

  // Top bit picks the crossing direction, low bits pick one event.
  wire pesnl_obuf_s obuf = if_sel[2] ? i_rev_obuf : i_fwd_obuf;
  wire         if_hit   = (if_sel[1:0] == IF_PACKET) ? obuf.packet_emitted :
                          (if_sel[1:0] == IF_FLIT) ? obuf.flit_emitted :
                          (if_sel[1:0] == IF_STARVE) ? obuf.credit_starved : 1'b0;

  logic        tm_hit;

  pesnl_traffic_match u_match (
    .i_cfg     (tm_cfg),
    .i_fwd_pkt (i_fwd_pkt),
    .i_rev_pkt (i_rev_pkt),
    .o_hit     (tm_hit)
  );

  // An all-zero traffic field leaves traffic matching off.
  wire         home_hit = ecc_hit | if_hit | (tm_on & tm_hit);

  ////////////////////////////////////////////////////////////////////////////
  // Link-layer field extraction.

  wire [4:0]   ll_is    = link_layer_event_select[LL_PS_MSB:LL_PS_LSB];
  wire [2:0]   ll_ie    = link_layer_event_select[LL_EV_MSB:LL_EV_LSB];
  logic        ll_hit;

  pesnl_ll_path #(
    .N (LL_N)
  ) u_ll_path (
    .i_path_select (ll_is),
    .i_path_event  (ll_ie),
    .i_src_mask    (counter_setup_word.unit_src),
    .i_ev          (i_ll_ev),
    .o_hit         (ll_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter setup qualification.

  wire setup_common = counter_setup_word.enable_src == EN_LOCAL &&
                      counter_setup_word.event_src == EVSRC_UNIT &&
                      counter_setup_word.reset_src == RST_NONE &&
                      counter_setup_word.compare == CMP_OFF &&
                      counter_setup_word.mode == MODE_EVENTS;
  wire sel_home     = setup_common && counter_setup_word.unit_type == UTYPE_HOME &&
                      counter_setup_word.unit_src == USRC_HOME;
  wire sel_ll       = setup_common && counter_setup_word.unit_type == UTYPE_LL;
  wire count_inc    = (sel_home & home_hit) | (sel_ll & ll_hit);
  wire wrap         = count_inc & (count == COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Event counter and event outputs.

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count <= 32'h00000000;
    end else if (wr_en & hit_count) begin
      count <= i_pwdata;
    end else if (count_inc) begin
      count <= count + 32'h00000001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      home_event <= 1'b0;
      ll_event   <= 1'b0;
    end else begin
      home_event <= sel_home & home_hit;
      ll_event   <= sel_ll & ll_hit;
    end
  end

  assign o_home_event = home_event;
  assign o_ll_event   = ll_event;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event wins over a write-one clear in the same cycle.

  wire [IRQ_W-1:0] irq_set   = {wrap, sel_ll & ll_hit, sel_home & home_hit};
  wire [IRQ_W-1:0] irq_clr   = (wr_en & hit_stat) ? i_pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_stat = (irq_stat & ~irq_clr) | irq_set;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= next_stat;
      if (wr_en & hit_mask) begin
        irq_mask <= i_pwdata[IRQ_W-1:0];
      end
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

endmodule // pesnl_top

/* File: tb/pesnl_top_asserts.sv */
/*
  Checker for the event selector: shadows the select and setup words from APB writes
  and ties each event output to its causes at the inputs.
  Assumes it is bound onto pesnl_top and sees only its ports.
*/
`timescale 1ns/1ps
module pesnl_top_asserts
  import pesnl_pkg::*;
(
  input wire logic                          i_sys_clk,
  input wire logic                          i_rst,
  input wire logic [7:0]                    i_paddr,
  input wire logic                          i_psel,
  input wire logic                          i_penable,
  input wire logic                          i_pwrite,
  input wire logic [31:0]                   i_pwdata,
  input wire logic [31:0]                   o_prdata,
  input wire logic                          o_pready,
  input wire logic                          o_pslverr,
  input wire logic [3:0]                    i_ecc_err,
  input wire pesnl_pkg::pesnl_obuf_s        i_fwd_obuf,
  input wire pesnl_pkg::pesnl_obuf_s        i_rev_obuf,
  input wire pesnl_pkg::pesnl_pkt_s         i_fwd_pkt,
  input wire pesnl_pkg::pesnl_pkt_s         i_rev_pkt,
  input wire pesnl_pkg::pesnl_ll_ev_s [8:0] i_ll_ev,
  input wire logic                          o_home_event,
  input wire logic                          o_ll_event,
  input wire logic                          o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0]  h_lo, h_mid, ll_lo, setup;
  logic [9:0]   h_hi;
  logic         ll_hi;
  logic [8:0]   llv;
  wire          wr = i_psel && i_penable && i_pwrite;
  wire [73:0]   home = {h_hi, h_mid, h_lo};
  wire [32:0]   llw = {ll_hi, ll_lo};
  wire pesnl_match_s m = home[TM_MSB:TM_LSB];
  wire [2:0]    ifs = home[IF_MSB:IF_LSB];
  wire [4:0]    ps = llw[LL_PS_MSB:LL_PS_LSB];
  wire [2:0]    pe = llw[LL_EV_MSB:LL_EV_LSB];
  wire pesnl_pkt_s  p = m.rev_dir ? i_rev_pkt : i_fwd_pkt;
  wire pesnl_obuf_s obsel = ifs[2] ? i_rev_obuf : i_fwd_obuf;
  wire          ecc_hit = |(i_ecc_err & home[ECC_MSB:ECC_LSB]);
  wire          if_hit = ifs[1:0] != 2'h0 && obsel[2'h3 - ifs[1:0]];
  wire          tm_hit = m != '0 && p.valid && ((p.dest_node_id ^ m.dest_node_id) & m.dest_node_id_mask) == '0
                && ((p.requester_node_id ^ m.requester_node_id) & m.requester_node_id_mask) == '0
                && ((p.message_class ^ m.message_class) & m.message_class_mask) == '0
                && ((p.opcode_value ^ m.opcode_value) & m.opcode_mask) == '0;
  wire          cwr = wr && i_paddr == OFS_COUNT;
  wire          home_ok = setup == 32'h00100004 && !cwr;
  wire          ll_ok = setup[31:29] == 3'h1 && setup[19:0] == 20'h00004 && !cwr;
  wire          ll_hit = |(llv & setup[28:20]);
  always_comb begin
    for (int k = 0; k < LL_N; k++) begin
      llv[k] = pe != 3'h0 && pe < 3'h5 && i_ll_ev[k][3'h4 - pe];
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      {h_lo, h_mid, h_hi, ll_lo, ll_hi, setup} <= '0;
    end else if (wr) begin
      case (i_paddr)
        OFS_HOME_LO:  h_lo <= i_pwdata;
        OFS_HOME_MID: h_mid <= i_pwdata;
        OFS_HOME_HI:  h_hi <= i_pwdata[9:0];
        OFS_LL_LO:    ll_lo <= i_pwdata;
        OFS_LL_HI:    ll_hi <= i_pwdata[0];
        OFS_SETUP:    setup <= i_pwdata;
        default:      ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  ecc_count_a: assert property (home_ok && ecc_hit |=> o_home_event)
    else $error("selected ECC error not counted");
  if_count_a: assert property (home_ok && if_hit |=> o_home_event)
    else $error("selected interface event not counted");
  match_count_a: assert property (home_ok && tm_hit |=> o_home_event)
    else $error("matching packet not counted");
  home_quiet_a: assert property (home_ok && !ecc_hit && !if_hit && !tm_hit ##1 1 |-> !o_home_event)
    else $error("home event counted without a selected cause");
  ll_count_a: assert property (ll_ok && ps == LL_PS_GOOD && ll_hit |=> o_ll_event)
    else $error("selected link-layer event not counted");
  ll_dead_a: assert property (ps != LL_PS_GOOD |=> !o_ll_event)
    else $error("non-functional path selection counted");
  ll_quiet_a: assert property (ll_ok && !ll_hit |=> !o_ll_event)
    else $error("unselected link-layer event counted");
  setup_gate_a: assert property (setup == 32'h0 [*2] |-> !o_home_event && !o_ll_event)
    else $error("event counted with a cleared setup word");
endmodule // pesnl_top_asserts

bind pesnl_top pesnl_top_asserts chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_ecc_err(i_ecc_err), .i_fwd_obuf(i_fwd_obuf), .i_rev_obuf(i_rev_obuf), .i_fwd_pkt(i_fwd_pkt),
  .i_rev_pkt(i_rev_pkt), .i_ll_ev(i_ll_ev), .o_home_event(o_home_event), .o_ll_event(o_ll_event), .o_irq(o_irq)
);

/* File: tb/pesnl_event_src.sv */
/*
  Far-side model: crossing paths, output buffers and link-layer instances that
  feed one-cycle event pulses and packet headers into the selector.
  Assumes the testbench calls fire from a single process.
*/
`timescale 1ns/1ps
module pesnl_event_src
  import pesnl_pkg::*;
(
  input  wire logic                      i_clk,
  output logic [3:0]                     o_ecc_err,
  output pesnl_pkg::pesnl_obuf_s         o_fwd_obuf,
  output pesnl_pkg::pesnl_obuf_s         o_rev_obuf,
  output pesnl_pkg::pesnl_pkt_s          o_fwd_pkt,
  output pesnl_pkg::pesnl_pkt_s          o_rev_pkt,
  output pesnl_pkg::pesnl_ll_ev_s [8:0]  o_ll_ev
);
  initial begin
    {o_ecc_err, o_fwd_obuf, o_rev_obuf, o_ll_ev} = '0;
    o_fwd_pkt = {1'b0, 18'h2AAAA};
    o_rev_pkt = {1'b0, 18'h15555};
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Raises one event for one cycle; idle headers show bitwise-inverted contents.
  task automatic fire(input int kind, input int idx, input pesnl_pkt_s hdr);
    @(posedge i_clk);
    case (kind)
      0:       o_ecc_err[idx] <= 1'b1;
      1:       o_fwd_obuf[idx] <= 1'b1;
      2:       o_rev_obuf[idx] <= 1'b1;
      3:       o_fwd_pkt <= hdr;
      4:       o_rev_pkt <= hdr;
      default: o_ll_ev[idx / 4][idx % 4] <= 1'b1;
    endcase
    @(posedge i_clk);
    {o_ecc_err, o_fwd_obuf, o_rev_obuf, o_ll_ev} <= '0;
    o_fwd_pkt <= {1'b0, ~o_fwd_pkt[17:0]};
    o_rev_pkt <= {1'b0, ~o_rev_pkt[17:0]};
  endtask
endmodule // pesnl_event_src

/* File: tb/test_pesnl_top.sv */
/*
  Testbench for the event selector: APB tasks program the select and setup words,
  the far-side model raises events, and outputs and registers are compared.
  Assumes APB answers within 15 cycles of the access phase, with wait states as the slave may give them.
*/
`timescale 1ns/1ps
module test_pesnl_top;
  import pesnl_pkg::*;
  logic               clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata;
  logic               pready, pslverr, home_ev, ll_ev, irq;
  logic [3:0]         ecc;
  pesnl_obuf_s        fob, rob;
  pesnl_pkt_s         fpk, rpk;
  pesnl_ll_ev_s [8:0] lle;
  int                 err_total = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  pesnl_event_src far_u (.i_clk(clk), .o_ecc_err(ecc), .o_fwd_obuf(fob), .o_rev_obuf(rob),
    .o_fwd_pkt(fpk), .o_rev_pkt(rpk), .o_ll_ev(lle));
  pesnl_top dut_u (.i_sys_clk(clk), .i_rst(rst), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ecc_err(ecc), .i_fwd_obuf(fob), .i_rev_obuf(rob), .i_fwd_pkt(fpk), .i_rev_pkt(rpk), .i_ll_ev(lle),
    .o_home_event(home_ev), .o_ll_event(ll_ev), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("counts: %0d compared, %0d unexpected", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("unexpected pready: expected 1, seen timeout");
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk({what, " error"}, {31'h0, experr}, {31'h0, e});
  endtask
  task automatic home(input logic [73:0] w);
    wr(OFS_HOME_LO, w[31:0]);
    wr(OFS_HOME_MID, w[63:32]);
    wr(OFS_HOME_HI, {22'h0, w[73:64]});
  endtask
  task automatic ll(input logic [32:0] w);
    wr(OFS_LL_LO, w[31:0]);
    wr(OFS_LL_HI, {31'h0, w[32]});
  endtask
  task automatic ev(input string what, input int kind, input int idx, input pesnl_pkt_s hdr, input logic [1:0] exp);
    far_u.fire(kind, idx, hdr);
    #1 chk(what, {30'h0, exp}, {30'h0, home_ev, ll_ev});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("unexpected run length: expected end, seen timeout");
    conclude();
  end
  initial begin
    logic [73:0] w;
    pesnl_match_s m;
    pesnl_pkt_s hg;
    static logic [31:0] grp [3] = '{32'h3E000004, 32'h21800004, 32'h20700004};
    static int hit_i [3] = '{8, 4, 0};
    static int miss_i [3] = '{0, 5, 3};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd("setup reset", OFS_SETUP, 32'h0, 1'b0);
    rd("count reset", OFS_COUNT, 32'h0, 1'b0);
    rd("unmapped read", 8'h24, 32'h0, 1'b1);
    $display("test registers done");
    wr(OFS_SETUP, 32'h00100004);
    w = '0;
    w[ECC_MSB:ECC_LSB] = 4'h3;
    home(w);
    for (int b = 0; b < 4; b++) ev("ecc event", 0, b, '0, {b < 2, 1'b0});
    $display("test ecc done");
    for (int d = 0; d < 2; d++) begin
      for (int c = 1; c < 4; c++) begin
        w = '0;
        w[IF_MSB:IF_LSB] = {d[0], c[1:0]};
        home(w);
        ev("interface event", 1 + d, 3 - c, '0, 2'b10);
        ev("interface other direction", 2 - d, 3 - c, '0, 2'b00);
        ev("interface other event", 1 + d, (4 - c) % 3, '0, 2'b00);
      end
    end
    $display("test interface done");
    m = '0;
    m.dest_node_id = 5'h0A;
    m.dest_node_id_mask = 5'h1F;
    m.message_class = 4'h3;
    m.message_class_mask = 4'hC;
    w = '0;
    w[TM_MSB:TM_LSB] = m;
    home(w);
    hg = '{1'b1, 5'h0A, 5'h15, 4'h2, 4'h7};
    ev("match hit", 3, 0, hg, 2'b10);
    ev("match node", 3, 0, '{1'b1, 5'h0B, 5'h15, 4'h2, 4'h7}, 2'b00);
    ev("match class", 3, 0, '{1'b1, 5'h0A, 5'h15, 4'h7, 4'h7}, 2'b00);
    ev("match direction", 4, 0, hg, 2'b00);
    m.rev_dir = 1'b1;
    m.requester_node_id = 5'h15;
    m.requester_node_id_mask = 5'h1F;
    m.opcode_value = 4'h7;
    m.opcode_mask = 4'hF;
    w[TM_MSB:TM_LSB] = m;
    home(w);
    ev("match reverse", 4, 0, hg, 2'b10);
    ev("match opcode", 4, 0, '{1'b1, 5'h0A, 5'h15, 4'h2, 4'h6}, 2'b00);
    wr(OFS_SETUP, 32'h00110004);
    ev("setup refused", 4, 0, hg, 2'b00);
    wr(OFS_SETUP, 32'h0);
    ev("setup cleared", 4, 0, hg, 2'b00);
    rd("home count", OFS_COUNT, 32'hA, 1'b0);
    rd("home status", OFS_IRQ_STAT, 32'h1, 1'b0);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_MASK, 32'h1);
    #1 chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_STAT, 32'h1);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test match and interrupt done");
    wr(OFS_SETUP, 32'h3FF00004);
    for (int e = 1; e < 5; e++) begin
      ll({5'h11, e[2:0], 25'h0});
      ev("ll event", 5, 32 + 4 - e, '0, 2'b01);
      ev("ll other event", 5, 32 + (5 - e) % 4, '0, 2'b00);
    end
    ll({5'h12, 3'h3, 25'h0});
    ev("ll dead path", 5, 33, '0, 2'b00);
    ll({5'h11, 3'h3, 25'h0});
    for (int g = 0; g < 3; g++) begin
      wr(OFS_SETUP, grp[g]);
      ev("ll group member", 5, hit_i[g] * 4 + 1, '0, 2'b01);
      ev("ll group outsider", 5, miss_i[g] * 4 + 1, '0, 2'b00);
    end
    rd("ll count", OFS_COUNT, 32'h11, 1'b0);
    wr(OFS_COUNT, 32'hFFFFFFFF);
    ev("ll wrap event", 5, 1, '0, 2'b01);
    rd("wrap count", OFS_COUNT, 32'h0, 1'b0);
    rd("ll status", OFS_IRQ_STAT, 32'h6, 1'b0);
    $display("test link layer done");
    conclude();
  end
endmodule // test_pesnl_top
